// file: rtl/sdc_defs.svh
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
// mode word fields
`define SDC_MODE_W        12
`define SDC_MODE_OPT_HI   11
`define SDC_MODE_OPT_LO   8
`define SDC_MODE_LAT_HI   6
`define SDC_MODE_LAT_LO   4
`define SDC_MODE_BT_BIT   3
`define SDC_MODE_BL_HI    2
`define SDC_MODE_BL_LO    0
`define SDC_MODE_RESET    12'h000
// address bit roles
`define SDC_BANK_BIT      11
`define SDC_AP_BIT        10
`define SDC_COL_W         8
// burst length codes
`define SDC_BL_1          3'h0
`define SDC_BL_2          3'h1
`define SDC_BL_4          3'h2
`define SDC_BL_8          3'h3
`define SDC_BL_PAGE       3'h7
`define SDC_PAGE_LEN      9'h100
`define SDC_LAT_MAX       3'h7
`endif

// file: rtl/sdc_pkg.sv
package sdc_pkg;
  typedef enum logic [3:0] {
    SDC_CMD_DESELECT, SDC_CMD_NOP, SDC_CMD_BURST_TERM, SDC_CMD_READ,
    SDC_CMD_WRITE, SDC_CMD_ROW_OPEN, SDC_CMD_BANK_CLOSE, SDC_CMD_REFRESH,
    SDC_CMD_MODE_LOAD
  } sdc_cmd_t;
  typedef enum logic [2:0] {
    SDC_BANK_IDLE, SDC_BANK_ACTIVE, SDC_BANK_READ, SDC_BANK_WRITE,
    SDC_BANK_READ_AP, SDC_BANK_WRITE_AP
  } sdc_bank_t;
endpackage

// file: rtl/sdc_buf2.sv
`timescale 1ns/1ps
module sdc_buf2 (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // fill side
  input  wire logic        in_valid_in,
  output logic             in_ready_out,
  input  wire logic [8:0]  in_data_in,
  // drain side
  output logic             out_valid_out,
  input  wire logic        out_ready_in,
  output logic [8:0]       out_data_out
);
  logic [8:0] mem_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  wire        push = in_valid_in && (count_reg != 2'h2);
  wire        pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      mem_reg[0] <= 9'h000;
      mem_reg[1] <= 9'h000;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data_in;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// file: rtl/sdc_core.sv
// Behaviour
// [R1] decode cs,ras,cas,we into deselect, nop, terminate, read, write, open, close, refresh, load
// [R2] read/write: A11 picks bank, A10 high adds auto-precharge
// [R3] row open: A11 picks bank, other lines give row, other bank unchanged
// [R4] close with A10 high idles both banks, else only A11 bank
// [R5] read/write column from A0..A7, A8 and A9 ignored
// [R6] track six bank states; access on one bank ends other's burst
// [R7] controller idles both banks before refresh, load, power-down; the bench drops clock-enable with bank 0 active
// [R8] clock-enable rising reactivates inputs at once, no sampled edge waited
// [R9] controller holds clock-enable and masks high 100 us before init; the model has no mask pins and holds only clock-enable high
// [R10] init: close all, two or more refreshes, then mode load
// [R11] mode load may come before the refreshes
// [R12] mode load copies all twelve address lines into the mode word
// [R13] mode word: options 11..8, latency 6..4, type 3, length 2..0
// [R14] controller issues mode load only with both banks idle
// [R15] controller waits two cycles after mode load
// [R16] first read column appears after programmed latency
// [R17] one start column per access, following columns generated inside
// [R18] burst lengths one, two, four, eight and full page
// [R19] burst order sequential or interleaved by mode type bit; the core ignores the type bit at full-page length and runs sequential
// [R20] controller uses terminate only with full-page length
// [R21] auto-precharge bank goes idle right after burst ends
`timescale 1ns/1ps
`include "sdc_defs.svh"
module sdc_core (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // command pins
  input  wire logic        clk_enable_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        row_strobe_n_in,
  input  wire logic        col_strobe_n_in,
  input  wire logic        write_strobe_n_in,
  input  wire logic [11:0] addr_in,
  // state view
  output logic [2:0]       bank0_state_out,
  output logic [2:0]       bank1_state_out,
  output logic [11:0]      mode_word_out,
  output logic [10:0]      open_row0_out,
  output logic [10:0]      open_row1_out,
  // column stream
  output logic             col_valid_out,
  output logic             col_write_out,
  output logic             col_bank_out,
  output logic [7:0]       col_addr_out,
  input  wire logic        col_ready_in
);
  sdc_pkg::sdc_bank_t bank_reg [2];
  sdc_pkg::sdc_bank_t bank_next [2];
  sdc_pkg::sdc_cmd_t  cmd;
  logic [11:0] mode_reg;
  logic [10:0] row_reg [2];
  logic        burst_on_reg;
  logic        burst_bank_reg;
  logic        burst_wr_reg;
  logic [7:0]  start_reg;
  logic [8:0]  beat_reg;
  logic [2:0]  lat_reg;
  logic        buf_in_ready;
  logic        buf_valid;
  logic [8:0]  buf_data;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  // [R8] clock-enable reacts to its own level, no sampled edge needed
  wire live = clk_enable_in;
  // [R1] command truth table
  always_comb begin
    if (!live || chip_select_n_in)
      cmd = sdc_pkg::SDC_CMD_DESELECT;
    else begin
      case ({row_strobe_n_in, col_strobe_n_in, write_strobe_n_in})
        3'h7:    cmd = sdc_pkg::SDC_CMD_NOP;
        3'h6:    cmd = sdc_pkg::SDC_CMD_BURST_TERM;
        3'h5:    cmd = sdc_pkg::SDC_CMD_READ;
        3'h4:    cmd = sdc_pkg::SDC_CMD_WRITE;
        3'h3:    cmd = sdc_pkg::SDC_CMD_ROW_OPEN;
        3'h2:    cmd = sdc_pkg::SDC_CMD_BANK_CLOSE;
        3'h1:    cmd = sdc_pkg::SDC_CMD_REFRESH;
        default: cmd = sdc_pkg::SDC_CMD_MODE_LOAD;
      endcase
    end
  end

  wire        is_rd   = (cmd == sdc_pkg::SDC_CMD_READ);
  wire        is_wr   = (cmd == sdc_pkg::SDC_CMD_WRITE);
  wire        is_acc  = is_rd || is_wr;
  // [R2] bank and auto-precharge select
  wire        sel     = addr_in[`SDC_BANK_BIT];
  wire        ap      = addr_in[`SDC_AP_BIT];
  // [R5] column from low lines only
  wire [7:0]  col_in  = addr_in[`SDC_COL_W-1:0];
  // [R13] mode word fields
  wire [2:0]  bl      = mode_reg[`SDC_MODE_BL_HI:`SDC_MODE_BL_LO];
  wire        ilv     = mode_reg[`SDC_MODE_BT_BIT];
  wire [2:0]  lat     = mode_reg[`SDC_MODE_LAT_HI:`SDC_MODE_LAT_LO];

  ////////////////////////////////////////////////////////////////////////
  // burst length and column generation
  // [R18] beats per programmed length
  wire [8:0] blen = (bl == `SDC_BL_1)    ? 9'h001 :
                    (bl == `SDC_BL_2)    ? 9'h002 :
                    (bl == `SDC_BL_4)    ? 9'h004 :
                    (bl == `SDC_BL_8)    ? 9'h008 :
                    (bl == `SDC_BL_PAGE) ? `SDC_PAGE_LEN : 9'h001;
  wire [7:0] wrap_mask = blen[8] ? 8'hFF : (blen[7:0] - 8'h01);
  wire [7:0] beat8     = beat_reg[7:0];
  // [R19] sequential adds, interleaved xors, inside the wrap window
  wire [7:0] seq_off   = (start_reg + beat8) & wrap_mask;
  wire [7:0] ilv_off   = (start_reg ^ beat8) & wrap_mask;
  // [R17] generated column for the current beat
  wire [7:0] gen_col   = (start_reg & ~wrap_mask) |
                         ((ilv && !blen[8]) ? ilv_off : seq_off);
  wire       data_phase = burst_on_reg && (lat_reg == 3'h0);
  wire       beat_fire  = data_phase && buf_in_ready;
  wire       last_beat  = beat_fire && (beat_reg == blen - 9'h001);
  wire       close_hit  = (cmd == sdc_pkg::SDC_CMD_BANK_CLOSE) &&
                          (ap || sel == burst_bank_reg);

  ////////////////////////////////////////////////////////////////////////
  // bank state transitions
  generate
    for (genvar b = 0; b < 2; b++) begin : g_bank
      wire mine    = (sel == 1'(b));
      wire bursting = (bank_reg[b] != sdc_pkg::SDC_BANK_IDLE) &&
                      (bank_reg[b] != sdc_pkg::SDC_BANK_ACTIVE);
      wire ends    = last_beat && (burst_bank_reg == 1'(b));
      always_comb begin
        bank_next[b] = bank_reg[b];
        // [R21] auto-precharge bank idles after its burst
        if (ends)
          bank_next[b] = (bank_reg[b] == sdc_pkg::SDC_BANK_READ_AP ||
                          bank_reg[b] == sdc_pkg::SDC_BANK_WRITE_AP) ?
                         sdc_pkg::SDC_BANK_IDLE : sdc_pkg::SDC_BANK_ACTIVE;
        case (cmd)
          sdc_pkg::SDC_CMD_BURST_TERM: begin
            // [R6] terminate returns burst to active
            if (bursting)
              bank_next[b] = sdc_pkg::SDC_BANK_ACTIVE;
          end
          sdc_pkg::SDC_CMD_READ, sdc_pkg::SDC_CMD_WRITE: begin
            // [R2] access enters plain or auto-precharge state
            if (mine)
              bank_next[b] = is_rd ?
                (ap ? sdc_pkg::SDC_BANK_READ_AP : sdc_pkg::SDC_BANK_READ) :
                (ap ? sdc_pkg::SDC_BANK_WRITE_AP : sdc_pkg::SDC_BANK_WRITE);
            // [R6] access on other bank ends this burst
            else if (bursting)
              bank_next[b] = sdc_pkg::SDC_BANK_ACTIVE;
          end
          sdc_pkg::SDC_CMD_ROW_OPEN: begin
            // [R3] only the selected bank opens
            if (mine)
              bank_next[b] = sdc_pkg::SDC_BANK_ACTIVE;
          end
          sdc_pkg::SDC_CMD_BANK_CLOSE: begin
            // [R4] all banks or the selected one
            if (ap || mine)
              bank_next[b] = sdc_pkg::SDC_BANK_IDLE;
          end
          default: ;
        endcase
      end
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          bank_reg[b] <= sdc_pkg::SDC_BANK_IDLE;
          row_reg[b]  <= 11'h000;
        end else begin
          bank_reg[b] <= bank_next[b];
          if (cmd == sdc_pkg::SDC_CMD_ROW_OPEN && mine)
            row_reg[b] <= addr_in[10:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // mode word and burst sequencer
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_reg       <= `SDC_MODE_RESET;
      burst_on_reg   <= 1'b0;
      burst_bank_reg <= 1'b0;
      burst_wr_reg   <= 1'b0;
      start_reg      <= 8'h00;
      beat_reg       <= 9'h000;
      lat_reg        <= 3'h0;
    end else begin
      // [R12] load whole address into mode word
      if (cmd == sdc_pkg::SDC_CMD_MODE_LOAD)
        mode_reg <= addr_in;
      if (is_acc) begin
        burst_on_reg   <= 1'b1;
        burst_bank_reg <= sel;
        burst_wr_reg   <= is_wr;
        start_reg      <= col_in;
        beat_reg       <= 9'h000;
        // [R16] read waits latency-1 cycles before first column
        lat_reg        <= (is_rd && lat != 3'h0) ? lat - 3'h1 : 3'h0;
      end else if (cmd == sdc_pkg::SDC_CMD_BURST_TERM || close_hit) begin
        burst_on_reg <= 1'b0;
      end else if (burst_on_reg) begin
        if (lat_reg != 3'h0)
          lat_reg <= lat_reg - 3'h1;
        else if (beat_fire) begin
          beat_reg <= beat_reg + 9'h001;
          if (last_beat)
            burst_on_reg <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // column stream buffer
  sdc_buf2 u_buf (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .in_valid_in   (beat_fire),
    .in_ready_out  (buf_in_ready),
    .in_data_in    ({burst_wr_reg, gen_col}),
    .out_valid_out (buf_valid),
    .out_ready_in  (col_ready_in),
    .out_data_out  (buf_data)
  );

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bank0_state_out <= 3'h0;
      bank1_state_out <= 3'h0;
      mode_word_out   <= `SDC_MODE_RESET;
      open_row0_out   <= 11'h000;
      open_row1_out   <= 11'h000;
      col_valid_out   <= 1'b0;
      col_write_out   <= 1'b0;
      col_bank_out    <= 1'b0;
      col_addr_out    <= 8'h00;
    end else begin
      bank0_state_out <= bank_next[0];
      bank1_state_out <= bank_next[1];
      mode_word_out   <= (cmd == sdc_pkg::SDC_CMD_MODE_LOAD) ? addr_in : mode_reg;
      open_row0_out   <= row_reg[0];
      open_row1_out   <= row_reg[1];
      col_valid_out   <= buf_valid && col_ready_in;
      col_write_out   <= buf_data[8];
      col_bank_out    <= burst_bank_reg;
      col_addr_out    <= buf_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_load;
    cmd == sdc_pkg::SDC_CMD_MODE_LOAD;
  endsequence
  // no command in flight for one cycle
  sequence s_quiet;
    cmd == sdc_pkg::SDC_CMD_NOP || cmd == sdc_pkg::SDC_CMD_DESELECT;
  endsequence
  // [R12] mode word load
  chk_mode_load_word: assert property (@(posedge clock_in) disable iff (rst_in) // [R12]
    s_load |=> mode_reg == $past(addr_in)) else $error("mode word not loaded");
  chk_open_sel_bank: assert property (@(posedge clock_in) disable iff (rst_in) // [R3]
    cmd == sdc_pkg::SDC_CMD_ROW_OPEN |=> bank_reg[$past(sel)] == sdc_pkg::SDC_BANK_ACTIVE)
    else $error("row open missed bank");
  chk_close_all_banks: assert property (@(posedge clock_in) disable iff (rst_in) // [R4]
    cmd == sdc_pkg::SDC_CMD_BANK_CLOSE && ap |=>
    bank_reg[0] == sdc_pkg::SDC_BANK_IDLE && bank_reg[1] == sdc_pkg::SDC_BANK_IDLE)
    else $error("close all failed");
  chk_read_ap_state: assert property (@(posedge clock_in) disable iff (rst_in) // [R2]
    is_rd && ap |=> bank_reg[$past(sel)] == sdc_pkg::SDC_BANK_READ_AP)
    else $error("read precharge state wrong");
  chk_term_to_active: assert property (@(posedge clock_in) disable iff (rst_in) // [R6]
    cmd == sdc_pkg::SDC_CMD_BURST_TERM |=>
    bank_reg[0] inside {sdc_pkg::SDC_BANK_IDLE, sdc_pkg::SDC_BANK_ACTIVE} &&
    bank_reg[1] inside {sdc_pkg::SDC_BANK_IDLE, sdc_pkg::SDC_BANK_ACTIVE})
    else $error("terminate left burst");
  chk_col_start: assert property (@(posedge clock_in) disable iff (rst_in) // [R5]
    is_acc |=> start_reg == $past(addr_in[7:0])) else $error("start column wrong");
  chk_ap_idle_end: assert property (@(posedge clock_in) disable iff (rst_in) // [R21]
    last_beat && !is_acc && cmd != sdc_pkg::SDC_CMD_ROW_OPEN &&
    cmd != sdc_pkg::SDC_CMD_BURST_TERM &&
    (bank_reg[burst_bank_reg] == sdc_pkg::SDC_BANK_READ_AP ||
     bank_reg[burst_bank_reg] == sdc_pkg::SDC_BANK_WRITE_AP) |=>
    bank_reg[$past(burst_bank_reg)] == sdc_pkg::SDC_BANK_IDLE)
    else $error("auto precharge missed");
  chk_read_latency: assert property (@(posedge clock_in) disable iff (rst_in) // [R16]
    is_rd && lat == 3'h2 ##1 s_quiet |-> lat_reg == 3'h1 ##1 lat_reg == 3'h0)
    else $error("latency count wrong");
endmodule

// file: sim/sdc_ctrl_model.sv
`timescale 1ns/1ps
module sdc_ctrl_model #(
  parameter int STARTUP_CYCLES = 4000
) (
  // clock
  input  wire logic        clock_in,
  // command pins
  output logic             clk_enable_out,
  output logic             chip_select_n_out,
  output logic             row_strobe_n_out,
  output logic             col_strobe_n_out,
  output logic             write_strobe_n_out,
  output logic [11:0]      addr_out
);
  initial begin
    clk_enable_out = 1'b1;
    {chip_select_n_out, row_strobe_n_out, col_strobe_n_out, write_strobe_n_out} = 4'hF;
    addr_out = 12'h000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // pins packed as cs, row, col, write strobe; held for one taking edge
  task automatic cmd(input logic [3:0] pins, input logic [11:0] addr);
    @(posedge clock_in);
    {chip_select_n_out, row_strobe_n_out, col_strobe_n_out, write_strobe_n_out} <= pins;
    addr_out <= addr;
    @(posedge clock_in);
    {chip_select_n_out, row_strobe_n_out, col_strobe_n_out, write_strobe_n_out} <= 4'h7;
    // released address carries no stale value
    addr_out <= ~addr;
  endtask
  task automatic cke(input logic v);
    @(posedge clock_in);
    clk_enable_out <= v;
  endtask
  // close all banks first, two spare cycles after load
  task automatic mode_load(input logic [11:0] word);
    cmd(4'h2, 12'h400);
    cmd(4'h0, word);
    repeat (2) @(posedge clock_in);
  endtask
  // settle with clock enable high, then close, load, refresh twice
  task automatic power_up(input logic [11:0] word);
    repeat (STARTUP_CYCLES) @(posedge clock_in);
    mode_load(word);
    repeat (2) cmd(4'h1, 12'h000);
  endtask
  // terminate is issued only under full-page length by the bench
endmodule

// file: sim/sdc_core_tb_top.sv
`timescale 1ns/1ps
module sdc_core_tb_top;
  logic        clock_in;
  logic        rst_in;
  logic        col_ready_in;
  logic        cke;
  wire  [3:0]  pins;
  logic [10:0] row0;
  logic [10:0] row1;
  int          t0 = 0;
  int          first_col = 0;
  logic [11:0] addr;
  logic [2:0]  b0_st;
  logic [2:0]  b1_st;
  logic [11:0] mode_w;
  logic        cv;
  logic        cw;
  logic        cb;
  logic [7:0]  ca;
  logic [9:0]  cols[$];
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  sdc_ctrl_model i_sdc_ctrl_model (.clock_in(clock_in), .clk_enable_out(cke),
    .chip_select_n_out(pins[3]), .row_strobe_n_out(pins[2]), .col_strobe_n_out(pins[1]),
    .write_strobe_n_out(pins[0]), .addr_out(addr));
  sdc_core i_sdc_core (.clock_in(clock_in), .rst_in(rst_in), .clk_enable_in(cke),
    .chip_select_n_in(pins[3]), .row_strobe_n_in(pins[2]), .col_strobe_n_in(pins[1]),
    .write_strobe_n_in(pins[0]), .addr_in(addr), .bank0_state_out(b0_st),
    .bank1_state_out(b1_st), .mode_word_out(mode_w), .open_row0_out(row0),
    .open_row1_out(row1),
    .col_valid_out(cv), .col_write_out(cw), .col_bank_out(cb), .col_addr_out(ca),
    .col_ready_in(col_ready_in));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_in) begin
    cycles++;
    if (cv === 1'b1 && cols.size() == 0) first_col = cycles;
    if (cv === 1'b1) cols.push_back({cw, cb, ca});
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic banks(input logic [2:0] s0, input logic [2:0] s1);
    #1;
    check({6'h00, b1_st, b0_st}, {6'h00, s1, s0});
  endtask
  // columns of one burst, listed as nibbles, first column in the top nibble
  task automatic burst(input logic [1:0] wb, input logic [31:0] nib, input int n);
    repeat (30) @(posedge clock_in);
    check(12'(cols.size()), 12'(n));
    for (int i = 0; i < n && i < cols.size(); i++) begin
      check({2'h0, cols[i]}, {2'h0, wb, 4'h0, nib[4*(n-1-i)+:4]});
    end
    cols.delete();
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    col_ready_in = 1'b1;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    i_sdc_ctrl_model.power_up(12'h022);
    #1 check(mode_w, 12'h022);
    banks(3'h0, 3'h0);
    $display("init test done");
    i_sdc_ctrl_model.cmd(4'h3, 12'h005);
    banks(3'h1, 3'h0);
    i_sdc_ctrl_model.cmd(4'hB, 12'h805);
    banks(3'h1, 3'h0);
    check({1'b0, row0}, 12'h005);
    i_sdc_ctrl_model.cke(1'b0);
    i_sdc_ctrl_model.cmd(4'h3, 12'h805);
    banks(3'h1, 3'h0);
    i_sdc_ctrl_model.cke(1'b1);
    i_sdc_ctrl_model.cmd(4'h3, 12'h805);
    banks(3'h1, 3'h1);
    $display("row open test done");
    i_sdc_ctrl_model.cmd(4'h4, 12'h305);
    banks(3'h3, 3'h1);
    check({1'b0, row1}, 12'h005);
    @(posedge clock_in);
    col_ready_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    col_ready_in <= 1'b1;
    burst(2'b10, 32'h5674, 4);
    $display("write stall test done");
    i_sdc_ctrl_model.cmd(4'h5, 12'h802);
    banks(3'h1, 3'h2);
    i_sdc_ctrl_model.cmd(4'h4, 12'h001);
    banks(3'h3, 3'h1);
    i_sdc_ctrl_model.cmd(4'h2, 12'h000);
    banks(3'h0, 3'h1);
    repeat (30) @(posedge clock_in);
    cols.delete();
    i_sdc_ctrl_model.cmd(4'h5, 12'hC02);
    banks(3'h0, 3'h4);
    t0 = cycles;
    burst(2'b01, 32'h2301, 4);
    check(12'(first_col - t0), 12'h004);
    banks(3'h0, 3'h0);
    $display("bank interplay test done");
    i_sdc_ctrl_model.mode_load(12'h02B);
    check(mode_w, 12'h02B);
    i_sdc_ctrl_model.cmd(4'h3, 12'h000);
    i_sdc_ctrl_model.cmd(4'h4, 12'h005);
    burst(2'b10, 32'h54761032, 8);
    $display("interleaved test done");
    i_sdc_ctrl_model.mode_load(12'h027);
    i_sdc_ctrl_model.cmd(4'h3, 12'h000);
    i_sdc_ctrl_model.cmd(4'h4, 12'h010);
    repeat (3) @(posedge clock_in);
    i_sdc_ctrl_model.cmd(4'h6, 12'h000);
    banks(3'h1, 3'h0);
    repeat (10) @(posedge clock_in);
    check({2'h0, cols[0]}, 12'h210);
    check(12'(cols.size() < 16), 12'h001);
    $display("full page test done");
    end_sim();
  end
endmodule
